/* shared/srt_pkg.sv */
/*
  Shared constants and types for the sync, reference and test-pattern register group.
  Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none

package srt_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets on the serial programming port
  localparam logic [14:0] OFS_SYNC = 15'h000E;     // Sync, reference and clock control
  localparam logic [14:0] OFS_DLL = 15'h0011;      // Delay-loop control
  localparam logic [14:0] OFS_TRIM = 15'h0013;     // Trim load control
  localparam logic [14:0] OFS_PAT_LO = 15'h0014;   // Pattern value bits 7:0
  localparam logic [14:0] OFS_PAT_MID = 15'h0015;  // Pattern value bits 15:8
  localparam logic [14:0] OFS_PAT_HI = 15'h0016;   // Modes and pattern value bits 17:16

  // Value of every register after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_PIN_ROLE = 7;     // Dual-purpose pin role
  localparam int BIT_SOFT_SYNC = 6;    // Software sync level
  localparam int BIT_SRC_SEL = 5;      // Sync source select
  localparam int BIT_STRAP_OVR = 3;    // Register fields override the strap
  localparam int REF_LSB = 1;          // Reference source field, two bits
  localparam int BIT_SE_CLK = 0;       // Single-ended clock select
  localparam int BIT_DLL_PD = 2;       // Delay-loop power down
  localparam int BIT_TRIM = 0;         // Trim load trigger
  localparam int MODE_B_LSB = 5;       // Channel B pattern mode, three bits
  localparam int MODE_A_LSB = 2;       // Channel A pattern mode, three bits
  localparam int PAT_HI_BITS = 2;      // Pattern value bits held in the high register

  //////////////////////////////////////////////////////////////////////////////
  // Field encodings
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_RAMP = 3'h2;
  localparam logic [2:0] MODE_CONST = 3'h3;
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame layout: read flag, 15-bit address, 8-bit data
  localparam int HDR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] HDR_LAST = 4'hF;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam int SAMPLE_BITS = 18;

  // Serial port sequencing
  typedef enum logic [1:0] {SER_IDLE, SER_HEAD, SER_DATA, SER_DONE} srt_ser_state_t;

  // Analog-facing configuration, all levels
  typedef struct packed {
    logic global_pd;     // Global power-down request
    logic sync_state;    // Internal sync state
    logic ref_external;  // External reference selected
    logic single_ended;  // Single-ended sample clock
    logic dll_pd;        // Delay-locked loop powered down
  } srt_cfg_t;

  // Trim load request
  typedef struct packed {
    logic load;          // One-cycle pulse
    logic [2:0] if_mode; // Interface mode captured with the pulse
  } srt_trim_t;

endpackage : srt_pkg

`default_nettype wire

/* hw/srt_pattern_gen.sv */
/*
  One channel of the output test-pattern generator: normal, ramp or constant.
  Assumes samples arrive with a one-cycle valid strobe on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module srt_pattern_gen
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration
  input wire logic [2:0] mode,
  input wire logic [17:0] pattern_value,
  // Sample stream
  input wire logic sample_valid,
  input wire logic [17:0] sample_in,
  output logic [17:0] sample_out
);

  logic [17:0] ramp_acc;   // Next ramp value to present
  logic [2:0] mode_prev;   // Mode seen last cycle, for entry detection
  wire logic is_ramp = (mode == srt_pkg::MODE_RAMP);
  wire logic is_const = (mode == srt_pkg::MODE_CONST);
  wire logic ramp_entry = is_ramp && (mode_prev != srt_pkg::MODE_RAMP);
  // Wraps modulo 2^18 by plain truncation of the sum
  wire logic [17:0] ramp_next = 18'(ramp_acc + pattern_value);

  //////////////////////////////////////////////////////////////////////////////
  // Mode history
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mode_prev <= srt_pkg::MODE_NORMAL;
    else
      mode_prev <= mode;
  end

  // Ramp accumulator restarts at zero on entry and steps once per sample
  always_ff @(posedge clk_sys)
  begin
    if (srst || !is_ramp)
      ramp_acc <= 18'h00000;
    else if (sample_valid)
      ramp_acc <= ramp_entry ? pattern_value : ramp_next;
  end

  // Output selection; unknown mode codes pass converted data through
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sample_out <= 18'h00000;
    else if (sample_valid)
    begin
      if (is_const)
        sample_out <= pattern_value;
      else if (is_ramp)
        sample_out <= ramp_entry ? 18'h00000 : ramp_acc;
      else
        sample_out <= sample_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  const_out_a: assert property (sample_valid && is_const |=> sample_out == $past(pattern_value))
    else $error("constant pattern not presented");
  ramp_start_a: assert property (sample_valid && ramp_entry |=> sample_out == 18'h00000)
    else $error("ramp did not start from zero");
  ramp_step_a: assert property (sample_valid && is_ramp && !ramp_entry && $stable(pattern_value)
                                ##1 sample_valid && is_ramp && $stable(pattern_value)
                                |=> sample_out == 18'($past(sample_out) + pattern_value))
    else $error("ramp step differs from pattern value");
  ramp_seen_c: cover property (sample_valid && is_ramp ##1 sample_valid && is_ramp);

endmodule : srt_pattern_gen

`default_nettype wire

/* hw/srt_regs.sv */
/*
  Sync, reference, delay-loop, trim-load and test-pattern register group of a
  dual-channel converter, written and read over the serial programming port.
  Assumes pins and straps are asynchronous to clk_sys and are synchronised here;
  converted samples and the interface mode come from logic on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module srt_regs
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial programming port
  input wire logic ser_enable_n,
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_en,
  // Dual-purpose pin and configuration strap
  input wire logic powerdown_sync_pin,
  input wire logic config_strap_pin,
  // Interface mode from the neighbouring register group
  input wire logic [2:0] if_mode,
  // Converted samples, index 0 is channel A, index 1 is channel B
  input wire logic sample_valid,
  input wire logic [1:0][17:0] sample_in,
  output logic [1:0][17:0] sample_out,
  // Configuration towards the analog core and fuse logic
  output srt_pkg::srt_cfg_t cfg,
  output srt_pkg::srt_trim_t trim
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, two flip-flops per pin
  logic [4:0] pin_meta;   // First stage, read only by the second
  logic [4:0] pin_sync;   // Second stage, safe to use
  logic sclk_prev;        // Previous synced serial clock, for edge detection

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pin_meta <= 5'h01;
      pin_sync <= 5'h01;
    end
    else
    begin
      pin_meta <= {config_strap_pin, powerdown_sync_pin, ser_din, ser_clk, ser_enable_n};
      pin_sync <= pin_meta;
    end
  end

  wire logic sen_n_s = pin_sync[0];
  wire logic sclk_s = pin_sync[1];
  wire logic sdi_s = pin_sync[2];
  wire logic pin_s = pin_sync[3];
  wire logic strap_s = pin_sync[4];

  // Serial clock edge detection on the synced copy only
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk_s;
  end

  wire logic sclk_rise = sclk_s && !sclk_prev;
  wire logic sclk_fall = !sclk_s && sclk_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage; reserved bits are kept as written
  logic [7:0] reg_sync;   // Sync, reference and clock control
  logic [7:0] reg_dll;    // Delay-loop control
  logic [7:0] reg_trim;   // Trim load control
  logic [7:0] pat_lo;     // Pattern value low byte
  logic [7:0] pat_mid;    // Pattern value middle byte
  logic [7:0] pat_hi;     // Pattern modes and top value bits

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame sequencing
  srt_pkg::srt_ser_state_t ser_state;
  srt_pkg::srt_ser_state_t next_ser_state;
  logic [3:0] bit_cnt;        // Bit index within header or data
  logic [14:0] hdr_shift;     // Header bits collected so far
  logic [14:0] frame_addr;    // Address of the current frame
  logic frame_read;           // Current frame is a read
  logic [7:0] data_shift;     // Write data being collected
  logic [7:0] dout_shift;     // Read data being sent

  wire logic [15:0] hdr_full = {hdr_shift, sdi_s};
  wire logic hdr_done = (ser_state == srt_pkg::SER_HEAD) && sclk_rise
                        && (bit_cnt == srt_pkg::HDR_LAST);
  wire logic data_done = (ser_state == srt_pkg::SER_DATA) && sclk_rise
                         && (bit_cnt == srt_pkg::DATA_LAST);
  wire logic [7:0] wr_byte = {data_shift[6:0], sdi_s};
  wire logic wr_fire = data_done && !frame_read;

  // Next-state decode; dropping the enable always aborts the frame
  always_comb
  begin
    next_ser_state = ser_state;
    if (sen_n_s)
      next_ser_state = srt_pkg::SER_IDLE;
    else
    begin
      unique case (ser_state)
        srt_pkg::SER_IDLE: next_ser_state = srt_pkg::SER_HEAD;
        srt_pkg::SER_HEAD: if (hdr_done) next_ser_state = srt_pkg::SER_DATA;
        srt_pkg::SER_DATA: if (data_done) next_ser_state = srt_pkg::SER_DONE;
        srt_pkg::SER_DONE: next_ser_state = srt_pkg::SER_DONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ser_state <= srt_pkg::SER_IDLE;
    else
      ser_state <= next_ser_state;
  end

  // Bit counter restarts at each phase boundary
  always_ff @(posedge clk_sys)
  begin
    if (srst || ser_state == srt_pkg::SER_IDLE || hdr_done)
      bit_cnt <= 4'h0;
    else if (sclk_rise)
      bit_cnt <= bit_cnt + 4'h1;
  end

  // Header capture; the address is frozen once the header completes
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      hdr_shift <= 15'h0000;
      frame_addr <= 15'h0000;
      frame_read <= 1'b0;
    end
    else if (ser_state == srt_pkg::SER_HEAD && sclk_rise)
    begin
      hdr_shift <= hdr_full[14:0];
      if (hdr_done)
      begin
        frame_read <= hdr_full[15];
        frame_addr <= hdr_full[14:0];
      end
    end
  end

  // Write data collection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      data_shift <= 8'h00;
    else if (ser_state == srt_pkg::SER_DATA && sclk_rise)
      data_shift <= wr_byte;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back multiplexer; unmapped addresses read as zero
  logic [7:0] rd_mux;
  wire logic [14:0] rd_addr = hdr_full[14:0];

  always_comb
  begin
    unique case (rd_addr)
      srt_pkg::OFS_SYNC: rd_mux = reg_sync;
      srt_pkg::OFS_DLL: rd_mux = reg_dll;
      srt_pkg::OFS_TRIM: rd_mux = reg_trim;
      srt_pkg::OFS_PAT_LO: rd_mux = pat_lo;
      srt_pkg::OFS_PAT_MID: rd_mux = pat_mid;
      srt_pkg::OFS_PAT_HI: rd_mux = pat_hi;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data shifts out MSB first on falling serial clock edges
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      dout_shift <= 8'h00;
      ser_dout <= 1'b0;
    end
    else if (hdr_done)
      dout_shift <= rd_mux;
    else if (ser_state == srt_pkg::SER_DATA && sclk_fall)
    begin
      ser_dout <= dout_shift[7];
      dout_shift <= {dout_shift[6:0], 1'b0};
    end
  end

  // The line is only driven during the data phase of a read
  assign ser_dout_en = (ser_state == srt_pkg::SER_DATA) && frame_read;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode
  wire logic wr_sync = wr_fire && (frame_addr == srt_pkg::OFS_SYNC);
  wire logic wr_dll = wr_fire && (frame_addr == srt_pkg::OFS_DLL);
  wire logic wr_trim = wr_fire && (frame_addr == srt_pkg::OFS_TRIM);
  wire logic wr_lo = wr_fire && (frame_addr == srt_pkg::OFS_PAT_LO);
  wire logic wr_mid = wr_fire && (frame_addr == srt_pkg::OFS_PAT_MID);
  wire logic wr_hi = wr_fire && (frame_addr == srt_pkg::OFS_PAT_HI);

  // Registers change only by host writes; nothing here clears a bit on its own
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      reg_sync <= srt_pkg::REG_RESET;
      reg_dll <= srt_pkg::REG_RESET;
      reg_trim <= srt_pkg::REG_RESET;
      pat_lo <= srt_pkg::REG_RESET;
      pat_mid <= srt_pkg::REG_RESET;
      pat_hi <= srt_pkg::REG_RESET;
    end
    else
    begin
      if (wr_sync) reg_sync <= wr_byte;
      if (wr_dll) reg_dll <= wr_byte;
      if (wr_trim) reg_trim <= wr_byte;
      if (wr_lo) pat_lo <= wr_byte;
      if (wr_mid) pat_mid <= wr_byte;
      if (wr_hi) pat_hi <= wr_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field extraction
  wire logic pin_is_sync = reg_sync[srt_pkg::BIT_PIN_ROLE];
  wire logic soft_sync_level = reg_sync[srt_pkg::BIT_SOFT_SYNC];
  wire logic sync_source_select = reg_sync[srt_pkg::BIT_SRC_SEL];
  wire logic strap_override = reg_sync[srt_pkg::BIT_STRAP_OVR];
  wire logic [1:0] ref_field = reg_sync[srt_pkg::REF_LSB +: 2];
  wire logic single_ended_clock_select = reg_sync[srt_pkg::BIT_SE_CLK];
  wire logic delay_loop_powerdown = reg_dll[srt_pkg::BIT_DLL_PD];
  wire logic trim_load_trigger = reg_trim[srt_pkg::BIT_TRIM];

  // Pin feeds sync only in its sync role, power-down only in the other
  wire logic pin_sync_level = pin_is_sync && pin_s;
  wire logic pin_pd_level = !pin_is_sync && pin_s;
  // Software level wins only when selected as the source
  wire logic next_sync = sync_source_select ? soft_sync_level : pin_sync_level;
  // Only code 10 selects the external reference; other codes stay internal
  wire logic ref_from_field = (ref_field == srt_pkg::REF_EXTERNAL);
  // Strap high means external reference and single-ended clock
  wire logic next_ref_ext = strap_override ? ref_from_field : strap_s;
  wire logic next_se = strap_override ? single_ended_clock_select : strap_s;

  // Configuration outputs are registered to keep them glitch free
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cfg <= '0;
    else
    begin
      cfg.global_pd <= pin_pd_level;
      cfg.sync_state <= next_sync;
      cfg.ref_external <= next_ref_ext;
      cfg.single_ended <= next_se;
      cfg.dll_pd <= delay_loop_powerdown;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trim load fires when the trigger falls, after the host's hold time
  logic trim_prev;  // Trigger value last cycle
  wire logic trim_fall = trim_prev && !trim_load_trigger;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      trim_prev <= 1'b0;
      trim <= '0;
    end
    else
    begin
      trim_prev <= trim_load_trigger;
      trim.load <= trim_fall;
      if (trim_fall)
        trim.if_mode <= if_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test-pattern generators, one per channel
  wire logic [17:0] pattern_value = {pat_hi[srt_pkg::PAT_HI_BITS-1:0], pat_mid, pat_lo};
  wire logic [1:0][2:0] ch_mode = {pat_hi[srt_pkg::MODE_B_LSB +: 3],
                                   pat_hi[srt_pkg::MODE_A_LSB +: 3]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      srt_pattern_gen u_gen
      (
        .clk_sys(clk_sys),
        .srst(srst),
        .mode(ch_mode[ch]),
        .pattern_value(pattern_value),
        .sample_valid(sample_valid),
        .sample_in(sample_in[ch]),
        .sample_out(sample_out[ch])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  pin_role_a: assert property (pin_is_sync |=> !cfg.global_pd)
    else $error("pin in sync role still drives power down");
  sync_src_a: assert property (sync_source_select && $stable(reg_sync)
                               |=> cfg.sync_state == $past(soft_sync_level))
    else $error("software sync level not followed");
  pin_sync_a: assert property (!sync_source_select && !pin_is_sync |=> !cfg.sync_state)
    else $error("sync state set while pin is in power-down role");
  soft_hold_a: assert property (soft_sync_level && !wr_sync |=> soft_sync_level)
    else $error("software sync level cleared itself");
  ref_field_a: assert property (strap_override && ref_field == srt_pkg::REF_INTERNAL
                                |=> !cfg.ref_external)
    else $error("internal reference code ignored");
  strap_path_a: assert property (!strap_override |=> cfg.single_ended == $past(strap_s)
                                 && cfg.ref_external == $past(strap_s))
    else $error("strap not followed");
  clk_sel_a: assert property (strap_override |=> cfg.single_ended == $past(single_ended_clock_select))
    else $error("clock select field not followed");
  dll_pd_a: assert property (wr_dll ##1 1'b1 |=> cfg.dll_pd == $past(wr_byte[srt_pkg::BIT_DLL_PD], 2))
    else $error("delay-loop power down not applied");
  trim_pulse_a: assert property (trim.load |=> !trim.load)
    else $error("trim load longer than one cycle");
  trim_cause_a: assert property ($fell(trim_load_trigger) |=> trim.load
                                 && trim.if_mode == $past(if_mode))
    else $error("trim load missing after trigger release");

  soft_sync_c: cover property (sync_source_select && $rose(cfg.sync_state));
  trim_c: cover property (trim.load);
  read_c: cover property (data_done && frame_read);
  const_c: cover property (ch_mode[0] == srt_pkg::MODE_CONST && sample_valid);

endmodule : srt_regs

`default_nettype wire

/* tb/srt_host_model.sv */
/*
  Host on the serial programming port: frames of read flag, address and data.
  Spaces frames itself, enable held high eight system cycles after each; every serial clock level is held six system cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module srt_host_model
(
  // Clock
  input wire logic clk_sys,
  // Serial port
  output logic ser_enable_n,
  output logic ser_clk,
  output logic ser_din,
  input wire logic ser_dout
);
  // Port idles with clock parked low and frame disabled
  initial
  begin
    ser_enable_n = 1'b1;
    ser_clk = 1'b0;
    ser_din = 1'b0;
  end

  // One whole frame; reads shift data in during the low phase of each data bit
  task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
    logic [23:0] word;
    word = {rd, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_sys);
    ser_enable_n = 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      ser_din = word[23 - i];
      repeat (6) @(negedge clk_sys);
      if (i >= 16)
        rdata = {rdata[6:0], ser_dout};
      ser_clk = 1'b1;
      repeat (6) @(negedge clk_sys);
      ser_clk = 1'b0;
    end
    repeat (6) @(negedge clk_sys);
    ser_enable_n = 1'b1;
    // Released data line flips so a stale bit is never mistaken for data
    ser_din = ~ser_din;
    repeat (8) @(negedge clk_sys);
  endtask : frame
endmodule : srt_host_model

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench for the register group: registers, config, trim, patterns.
  Assumes the host model drives the serial port; pins change on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic clk_sys, srst, pin, strap, valid;
  logic [2:0] if_mode;
  logic [1:0][17:0] s_in;
  logic [1:0][17:0] s_out;
  logic [7:0] rd;
  logic [13:0] tab [7];
  srt_pkg::srt_cfg_t cfg;
  srt_pkg::srt_trim_t trim;
  wire logic sen_n, sclk, sdin, sdout, sdout_en;
  int bad_count = 0;
  int checked = 0;
  int loads = 0;
  int en_cycles = 0;

  srt_regs srt_regs_i (.clk_sys(clk_sys), .srst(srst), .ser_enable_n(sen_n), .ser_clk(sclk),
    .ser_din(sdin), .ser_dout(sdout), .ser_dout_en(sdout_en), .powerdown_sync_pin(pin),
    .config_strap_pin(strap), .if_mode(if_mode), .sample_valid(valid), .sample_in(s_in),
    .sample_out(s_out), .cfg(cfg), .trim(trim));
  srt_host_model srt_host_model_i (.clk_sys(clk_sys), .ser_enable_n(sen_n), .ser_clk(sclk),
    .ser_din(sdin), .ser_dout(sdout));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Trim pulses are one cycle wide, so they are counted rather than looked at
  always @(posedge clk_sys) if (trim.load === 1'b1) loads <= loads + 1;
  // Cycles in which the device drives the read-data line
  always @(posedge clk_sys) if (sdout_en === 1'b1) en_cycles <= en_cycles + 1;

  task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_cfg(input srt_pkg::srt_cfg_t e);
    checked++;
    if (cfg !== e)
    begin
      bad_count++;
      $display("MISMATCH cfg expected %h seen %h", e, cfg);
    end
  endtask : cmp_cfg

  task automatic cmp_smp(input string n, input logic [17:0] e, input logic [17:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_smp

  // A write never turns the read-data driver on
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    int n;
    n = en_cycles;
    srt_host_model_i.frame(1'b0, a, d, rd);
    cmp_reg("dout_en", 8'h00, 8'(en_cycles - n));
  endtask : wr

  // A read drives the line for its whole data phase: 8 bits of 12 cycles
  task automatic chk(input logic [14:0] a, input logic [7:0] e);
    int n;
    n = en_cycles;
    srt_host_model_i.frame(1'b1, a, 8'h00, rd);
    cmp_reg("register", e, rd);
    cmp_reg("dout_en", 8'h60, 8'(en_cycles - n));
  endtask : chk

  // One sample strobe, then both channel outputs against expectation
  task automatic samp(input logic [17:0] ea, input logic [17:0] eb);
    @(negedge clk_sys);
    valid = 1'b1;
    @(negedge clk_sys);
    valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp_smp("chan_a", ea, s_out[0]);
    cmp_smp("chan_b", eb, s_out[1]);
  endtask : samp

  task automatic results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial
  begin
    srst = 1'b1;
    pin = 1'b0;
    strap = 1'b0;
    valid = 1'b0;
    if_mode = 3'h0;
    s_in[0] = 18'h12345;
    s_in[1] = 18'h2ABCD;
    // Strap, register value, expected cfg
    tab = '{{1'b1, 8'h00, 5'h06}, {1'b1, 8'h08, 5'h00}, {1'b1, 8'h0C, 5'h04},
      {1'b1, 8'h09, 5'h02}, {1'b1, 8'h0A, 5'h00}, {1'b0, 8'h0D, 5'h06}, {1'b0, 8'h06, 5'h00}};
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    repeat (4) @(negedge clk_sys);
    // Reset values, with the unmapped holes in between reading zero
    for (int a = 14; a < 23; a++) chk(15'(a), 8'h00);
    cmp_cfg(5'h00);
    wr(15'h0020, 8'h5A);
    chk(15'h0020, 8'h00);
    // Fill pattern keeps the trim trigger low, so no load fires before its own test
    for (int a = 14; a < 23; a++) wr(15'(a), 8'hA5 ^ 8'(a));
    for (int a = 14; a < 23; a++)
      chk(15'(a), (a == 15 || a == 16 || a == 18) ? 8'h00 : 8'hA5 ^ 8'(a));
    for (int a = 14; a < 23; a++) wr(15'(a), 8'h00);
    pin = 1'b1;
    wr(15'h000E, 8'h00);
    cmp_cfg(5'h10);
    wr(15'h000E, 8'h80);
    cmp_cfg(5'h08);
    wr(15'h000E, 8'hE0);
    repeat (50) @(negedge clk_sys);
    chk(15'h000E, 8'hE0);
    cmp_cfg(5'h08);
    wr(15'h000E, 8'hA0);
    cmp_cfg(5'h00);
    pin = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      strap = tab[i][13];
      wr(15'h000E, tab[i][12:5]);
      cmp_cfg(tab[i][4:0]);
    end
    wr(15'h0011, 8'h04);
    cmp_cfg(5'h01);
    wr(15'h0011, 8'hFB);
    cmp_cfg(5'h00);
    if_mode = 3'h5;
    wr(15'h0013, 8'h01);
    repeat (50000) @(negedge clk_sys);
    cmp_reg("loads", 8'h00, 8'(loads));
    wr(15'h0013, 8'h00);
    if_mode = 3'h2;
    repeat (4) @(negedge clk_sys);
    cmp_reg("loads", 8'h01, 8'(loads));
    cmp_reg("if_mode", 8'h05, {5'h00, trim.if_mode});
    // Pattern value 0x20001 makes the second ramp step wrap
    wr(15'h0014, 8'h01);
    wr(15'h0015, 8'h00);
    wr(15'h0016, 8'h6A);
    samp(18'h00000, 18'h20001);
    samp(18'h20001, 18'h20001);
    samp(18'h00002, 18'h20001);
    wr(15'h0016, 8'h4E);
    samp(18'h20001, 18'h00000);
    samp(18'h20001, 18'h20001);
    // Back-to-back strobes step the ramp on consecutive samples
    @(negedge clk_sys);
    valid = 1'b1;
    repeat (2) @(negedge clk_sys);
    valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp_smp("chan_a", 18'h20001, s_out[0]);
    cmp_smp("chan_b", 18'h20003, s_out[1]);
    wr(15'h0016, 8'h02);
    samp(18'h12345, 18'h2ABCD);
    results();
  end
endmodule : tb

`default_nettype wire
